// file: deg_driver_enable.sv
// driver enable gating and latched driver fault status word
`timescale 1ns/1ps

module deg_driver_enable (
	input  wire logic                          ref_clk,
	input  wire logic                          rst_n,
	input  wire logic                          drive_pin,
	input  wire logic                          clk_missing,
	input  wire logic                          gate_supply_low_flag,
	input  wire logic                          five_volt_low_flag,
	input  wire logic                          boost_low_flag,
	input  wire logic                          over_temp_flag,
	input  wire logic                          gnd_loss_flag,
	input  wire deg_pkg::deg_cfg_t             cfg,
	input  wire logic [deg_pkg::ADDR_W-1:0]    reg_addr,
	input  wire logic                          reg_rd,
	input  wire logic                          reg_wr,
	output logic      [deg_pkg::DATA_W-1:0]    reg_rdata,
	output logic      [deg_pkg::HS_N-1:0]      high_group_enable,
	output logic      [deg_pkg::LS_N-1:0]      low_group_enable
);

	deg_pkg::deg_flags_t  flags_raw;
	deg_pkg::deg_flags_t  fl;
	deg_pkg::deg_state_t  st_reg;
	deg_pkg::deg_state_t  st_next;

	logic                          clk_ok;
	logic                          supply_ok;
	logic                          boost_ok;
	logic                          base_ok;
	logic                          gate_err;
	logic                          rd_hit;
	logic                          wr_hit;
	logic                          clr;
	logic                          sync_live;
	logic [deg_pkg::STAT_W-1:0]    err;

	// pass the driver through when gated on and the pin or a bypass allows it
	function automatic logic pin_gate(input logic ok, input logic pin,
	                                  input logic bypass);
		pin_gate = ok && (pin || bypass);
	endfunction

	assign flags_raw.clk_missing          = clk_missing;
	assign flags_raw.drive_pin            = drive_pin;
	assign flags_raw.gate_supply_low_flag = gate_supply_low_flag;
	assign flags_raw.five_volt_low_flag   = five_volt_low_flag;
	assign flags_raw.boost_low_flag       = boost_low_flag;
	assign flags_raw.over_temp            = over_temp_flag;
	assign flags_raw.gnd_loss             = gnd_loss_flag;

	// all analog flags and the pin arrive unsynchronised
	deg_sync #(
		.W (deg_pkg::SYNC_W)
	) u_sync (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.async_in (flags_raw),
		.sync_out (fl)
	);

	always_comb begin
		st_next   = st_reg;
		// the synchroniser shows zeros for two edges after reset, which would
		// look like a low drive pin, so status is frozen until it has filled
		sync_live = (st_reg.warm == deg_pkg::SYNC_FILL);
		if (!sync_live) begin
			st_next.warm = st_reg.warm + 2'h1;
		end
		rd_hit    = reg_rd && (reg_addr == deg_pkg::FAULT_LATCH_ADDR);
		wr_hit    = reg_wr && (reg_addr == deg_pkg::FAULT_LATCH_ADDR);
		clr       = wr_hit || (rd_hit && cfg.reset_on_read_en);
		gate_err  = fl.gate_supply_low_flag || fl.gnd_loss;
		clk_ok    = !(cfg.clk_miss_disable && fl.clk_missing);
		supply_ok = !gate_err && !fl.five_volt_low_flag;
		boost_ok  = !(cfg.boost_disable_en && fl.boost_low_flag);
		base_ok   = clk_ok && supply_ok;

		for (int i = 0; i < deg_pkg::LS_N - 1; i++) begin
			st_next.low_en[i] = pin_gate(base_ok, fl.drive_pin,
				cfg.group_pin_bypass && (i == deg_pkg::LS_BYP_IDX0 ||
				i == deg_pkg::LS_BYP_IDX1));
		end
		st_next.low_en[deg_pkg::LS_SEVEN] = pin_gate(base_ok,
			fl.drive_pin, cfg.low_seven_pin_bypass);
		for (int i = 0; i < deg_pkg::HS_N; i++) begin
			st_next.high_en[i] = pin_gate(base_ok && boost_ok, fl.drive_pin,
				cfg.group_pin_bypass && (i == deg_pkg::HS_BYP_IDX));
		end

		// over temperature is only reported, never fed to the gating above
		err                         = '0;
		err[deg_pkg::ST_CLK_MISS]   = !clk_ok;
		err[deg_pkg::ST_OVER_TEMP]  = fl.over_temp;
		err[deg_pkg::ST_BOOST]      = !boost_ok;
		err[deg_pkg::ST_FIVE]       = fl.five_volt_low_flag;
		err[deg_pkg::ST_GATE]       = gate_err;

		// read data is the word before this access clears anything
		if (rd_hit) begin
			st_next.rdata = {deg_pkg::STAT_RSVD, st_reg.status};
			st_next.rdata[deg_pkg::ST_PIN_LIVE] = fl.drive_pin;
		end

		// a present error wins over a coinciding clear
		for (int b = 0; b < deg_pkg::STAT_W; b++) begin
			if (err[b]) begin
				st_next.status[b] = 1'b1;
			end else if (clr) begin
				st_next.status[b] = 1'b0;
			end
		end
		st_next.status[deg_pkg::ST_PIN_LIVE] = 1'b0;

		// pin history is inverted: low pin drops it, a clear rearms it
		if (!fl.drive_pin) begin
			st_next.status[deg_pkg::ST_PIN_HIST] = 1'b0;
		end else if (clr) begin
			st_next.status[deg_pkg::ST_PIN_HIST] = 1'b1;
		end else begin
			st_next.status[deg_pkg::ST_PIN_HIST] =
				st_reg.status[deg_pkg::ST_PIN_HIST];
		end

		// limitation: a clear asked for while frozen is dropped
		if (!sync_live) begin
			st_next.status = st_reg.status;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg.status  <= deg_pkg::STAT_RESET;
			st_reg.rdata   <= '0;
			st_reg.high_en <= '0;
			st_reg.low_en  <= '0;
			st_reg.warm    <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata         = st_reg.rdata;
	assign high_group_enable = st_reg.high_en;
	assign low_group_enable  = st_reg.low_en;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	ls_pin_gate_a: assert property (
		!fl.drive_pin && !cfg.group_pin_bypass
		|=> low_group_enable[5:0] == 6'h00)
		else $error("low drivers on while drive pin low");

	ls_supply_a: assert property (
		(gate_err || fl.five_volt_low_flag)
		|=> low_group_enable == 7'h00 && high_group_enable == 5'h00)
		else $error("drivers on during supply undervoltage");

	ls7_bypass_a: assert property (
		base_ok && cfg.low_seven_pin_bypass
		|=> low_group_enable[deg_pkg::LS_SEVEN])
		else $error("low seven not bypassing drive pin");

	hs_enable_a: assert property (
		base_ok && boost_ok && fl.drive_pin
		|=> high_group_enable == 5'h1f)
		else $error("high drivers off with all conditions met");

	boost_gate_a: assert property (
		cfg.boost_disable_en && fl.boost_low_flag
		|=> high_group_enable == 5'h00 && st_reg.status[deg_pkg::ST_BOOST])
		else $error("boost undervoltage did not gate high drivers");

	clk_gate_a: assert property (
		cfg.clk_miss_disable && fl.clk_missing
		|=> low_group_enable == 7'h00
		&& st_reg.status[deg_pkg::ST_CLK_MISS])
		else $error("missing clock did not disable drivers");

	group_bypass_a: assert property (
		base_ok && boost_ok && cfg.group_pin_bypass
		|=> high_group_enable[4] && low_group_enable[2] && low_group_enable[5])
		else $error("group bypass not applied");

	pin_history_a: assert property (
		sync_live && !fl.drive_pin
		|=> !st_reg.status[deg_pkg::ST_PIN_HIST])
		else $error("pin history kept one after pin low");

	warm_hold_a: assert property (
		!sync_live |=> $stable(st_reg.status))
		else $error("status changed while synchroniser filled");

	pin_rearm_a: assert property (
		sync_live && clr && fl.drive_pin
		|=> st_reg.status[deg_pkg::ST_PIN_HIST])
		else $error("clear with pin high did not rearm history");

	ls7_pin_a: assert property (
		!fl.drive_pin && !cfg.low_seven_pin_bypass
		|=> !low_group_enable[deg_pkg::LS_SEVEN])
		else $error("low seven on with pin low and no bypass");

	clk_free_a: assert property (
		!cfg.clk_miss_disable && supply_ok && fl.drive_pin
		|=> low_group_enable == 7'h7f)
		else $error("low drivers off with clock disable unused");

	clk_status_a: assert property (
		clk_ok && !st_reg.status[deg_pkg::ST_CLK_MISS]
		|=> !st_reg.status[deg_pkg::ST_CLK_MISS])
		else $error("clock missing bit set without disabling");

	boost_status_a: assert property (
		!(cfg.boost_disable_en && fl.boost_low_flag)
		&& !st_reg.status[deg_pkg::ST_BOOST]
		|=> !st_reg.status[deg_pkg::ST_BOOST])
		else $error("boost bit set without disabling");

	boost_free_a: assert property (
		!cfg.boost_disable_en && base_ok && fl.drive_pin
		|=> high_group_enable == 5'h1f)
		else $error("boost undervoltage gated drivers while unused");

	five_latch_a: assert property (
		fl.five_volt_low_flag |=> st_reg.status[deg_pkg::ST_FIVE])
		else $error("five volt undervoltage not latched");

	gate_latch_a: assert property (
		fl.gate_supply_low_flag || fl.gnd_loss
		|=> st_reg.status[deg_pkg::ST_GATE])
		else $error("gate supply or ground loss not latched");

	read_clear_a: assert property (
		sync_live && rd_hit && cfg.reset_on_read_en && !fl.over_temp
		|=> !st_reg.status[deg_pkg::ST_OVER_TEMP])
		else $error("read with reset on read did not clear");

	rdata_hold_a: assert property (
		!rd_hit |=> $stable(reg_rdata))
		else $error("read data changed without a read");

	rdata_word_a: assert property (
		rd_hit |=> reg_rdata[3:0] == $past(st_reg.status[3:0])
		&& reg_rdata[6:5] == $past(st_reg.status[6:5]))
		else $error("read data differs from status word");

	live_store_a: assert property (
		!st_reg.status[deg_pkg::ST_PIN_LIVE])
		else $error("live pin bit stored in status");

	live_pin_a: assert property (
		rd_hit |=> reg_rdata[deg_pkg::ST_PIN_LIVE] == $past(fl.drive_pin)
		&& reg_rdata[15:7] == 9'h000)
		else $error("live pin bit or reserved bits wrong");

	set_wins_a: assert property (
		clr && fl.over_temp |=> st_reg.status[deg_pkg::ST_OVER_TEMP])
		else $error("clear lost a present overtemperature");

	write_clear_a: assert property (
		sync_live && wr_hit && !fl.five_volt_low_flag
		|=> !st_reg.status[deg_pkg::ST_FIVE])
		else $error("write did not clear five volt bit");

	read_keep_a: assert property (
		rd_hit && !reg_wr && !cfg.reset_on_read_en
		&& st_reg.status[deg_pkg::ST_FIVE]
		|=> st_reg.status[deg_pkg::ST_FIVE])
		else $error("read cleared status without reset on read");

	ot_no_gate_a: assert property (
		fl.over_temp && base_ok && fl.drive_pin
		|=> low_group_enable == 7'h7f ##0 st_reg.status[deg_pkg::ST_OVER_TEMP])
		else $error("overtemperature changed drivers or not latched");

	drivers_on_c: cover property (low_group_enable == 7'h7f
		&& high_group_enable == 5'h1f);
	clear_on_read_c: cover property (rd_hit && cfg.reset_on_read_en
		##1 st_reg.status == 7'h20);
	clk_miss_c: cover property (cfg.clk_miss_disable && fl.clk_missing
		##1 fl.clk_missing [*3] ##1 !fl.clk_missing);
	pin_drop_c: cover property (sync_live && fl.drive_pin
		##1 !fl.drive_pin);
	write_clear_c: cover property (wr_hit && st_reg.status[deg_pkg::ST_FIVE]
		##1 !st_reg.status[deg_pkg::ST_FIVE]);

endmodule

// file: deg_mcu_model.sv
// controller side model issuing status word reads and writes
`timescale 1ns/1ps

module deg_mcu_model (
	input  wire logic                   ref_clk,
	output logic [deg_pkg::ADDR_W-1:0]  reg_addr,
	output logic                        reg_rd,
	output logic                        reg_wr
);
	initial begin
		reg_addr = 10'h000;
		reg_rd = 1'b0;
		reg_wr = 1'b0;
	end

	// strobe held over one rising edge; a write is the only clear path
	// unless reset on read is enabled
	task automatic xfer(input logic rd, input logic wr,
	                    input logic [deg_pkg::ADDR_W-1:0] a);
		@(negedge ref_clk);
		reg_addr = a;
		reg_rd = rd;
		reg_wr = wr;
		@(negedge ref_clk);
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		// address no longer qualified, so show a different pattern
		reg_addr = ~a;
	endtask
endmodule

// file: deg_pkg.sv
// package: constants and carriers for the driver enable gating block
package deg_pkg;

	localparam int unsigned ADDR_W    = 10;
	localparam int unsigned DATA_W    = 16;
	localparam int unsigned STAT_W    = 7;
	localparam int unsigned HS_N      = 5;
	localparam int unsigned LS_N      = 7;
	localparam int unsigned SYNC_W    = 7;

	// status word offset on the serial register path
	localparam logic [ADDR_W-1:0] FAULT_LATCH_ADDR = 10'h1d2;

	// status word bit positions
	localparam int unsigned ST_CLK_MISS  = 6;
	localparam int unsigned ST_PIN_HIST  = 5;
	localparam int unsigned ST_PIN_LIVE  = 4;
	localparam int unsigned ST_OVER_TEMP = 3;
	localparam int unsigned ST_BOOST     = 2;
	localparam int unsigned ST_FIVE      = 1;
	localparam int unsigned ST_GATE      = 0;

	// gate supply flagged low and pin history high out of reset
	localparam logic [STAT_W-1:0] STAT_RESET = 7'h21;
	localparam logic [DATA_W-STAT_W-1:0] STAT_RSVD = 9'h000;

	// edges after reset until the synchroniser holds real samples
	localparam logic [1:0] SYNC_FILL = 2'h2;

	// driver indices that the group bypass and the low seven bypass affect
	localparam int unsigned HS_BYP_IDX  = 4;
	localparam int unsigned LS_BYP_IDX0 = 2;
	localparam int unsigned LS_BYP_IDX1 = 5;
	localparam int unsigned LS_SEVEN    = 6;

	typedef struct packed {
		logic clk_missing;
		logic drive_pin;
		logic gate_supply_low_flag;
		logic five_volt_low_flag;
		logic boost_low_flag;
		logic over_temp;
		logic gnd_loss;
	} deg_flags_t;

	typedef struct packed {
		logic clk_miss_disable;
		logic boost_disable_en;
		logic low_seven_pin_bypass;
		logic group_pin_bypass;
		logic reset_on_read_en;
	} deg_cfg_t;

	typedef struct packed {
		logic [STAT_W-1:0] status;
		logic [DATA_W-1:0] rdata;
		logic [HS_N-1:0]   high_en;
		logic [LS_N-1:0]   low_en;
		logic [1:0]        warm;
	} deg_state_t;

endpackage

// file: deg_sync.sv
// two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ps

module deg_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} deg_sync_state_t;

	deg_sync_state_t st_reg;
	deg_sync_state_t st_next;

	// first stage feeds only the second stage
	always_comb begin
		st_next.meta   = async_in;
		st_next.stable = st_reg.meta;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sync_out = st_reg.stable;

endmodule

// file: testbench.sv
// self-checking bench for the driver enable gating block
`timescale 1ns/1ps

module testbench;
	logic                          ref_clk = 1'b0;
	logic                          rst_n = 1'b0;
	logic                          drive_pin = 1'b1;
	logic                          clk_missing = 1'b0;
	logic                          gate_supply_low_flag = 1'b0;
	logic                          five_volt_low_flag = 1'b0;
	logic                          boost_low_flag = 1'b0;
	logic                          over_temp_flag = 1'b0;
	logic                          gnd_loss_flag = 1'b0;
	deg_pkg::deg_cfg_t             cfg = '0;
	logic [deg_pkg::ADDR_W-1:0]    reg_addr;
	logic                          reg_rd;
	logic                          reg_wr;
	logic [deg_pkg::DATA_W-1:0]    reg_rdata;
	logic [deg_pkg::HS_N-1:0]      high_group_enable;
	logic [deg_pkg::LS_N-1:0]      low_group_enable;
	logic [31:0]                   seed = 32'h0000_0034;
	logic [31:0]                   r;
	logic [6:0]                    st = 7'h21;
	logic [15:0]                   rd_exp = 16'h0000;
	logic                          bad;
	logic [11:0]                   en;
	logic [15:0]                   seen;
	int                            n_fail = 0;
	int                            checked = 0;
	int                            cyc = 0;

	always #4 ref_clk = ~ref_clk;

	deg_driver_enable dut_u (
		.ref_clk(ref_clk), .rst_n(rst_n), .drive_pin(drive_pin),
		.clk_missing(clk_missing),
		.gate_supply_low_flag(gate_supply_low_flag),
		.five_volt_low_flag(five_volt_low_flag),
		.boost_low_flag(boost_low_flag), .over_temp_flag(over_temp_flag),
		.gnd_loss_flag(gnd_loss_flag), .cfg(cfg), .reg_addr(reg_addr),
		.reg_rd(reg_rd), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
		.high_group_enable(high_group_enable),
		.low_group_enable(low_group_enable)
	);

	deg_mcu_model mcu_u (
		.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_rd(reg_rd),
		.reg_wr(reg_wr)
	);

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// bit 4 and bit 5 are handled apart from the latched conditions
	function automatic logic [6:0] cond();
		return {cfg.clk_miss_disable & clk_missing, 2'h0, over_temp_flag,
		        cfg.boost_disable_en & boost_low_flag, five_volt_low_flag,
		        gate_supply_low_flag | gnd_loss_flag};
	endfunction

	// high drivers in bits 11..7, low drivers in bits 6..0
	function automatic logic [11:0] exp_en();
		logic        ok;
		logic [11:0] e;
		ok = !(cfg.clk_miss_disable && clk_missing) && !gnd_loss_flag &&
		     !gate_supply_low_flag && !five_volt_low_flag;
		e = {12{ok && drive_pin}};
		if (ok && cfg.group_pin_bypass) begin
			e[11] = 1'b1;
			e[5] = 1'b1;
			e[2] = 1'b1;
		end
		if (ok && cfg.low_seven_pin_bypass) begin
			e[6] = 1'b1;
		end
		if (cfg.boost_disable_en && boost_low_flag) begin
			e[11:7] = 5'h00;
		end
		return e;
	endfunction

	task automatic chk(input string nm, input logic [15:0] e,
	                   input logic [15:0] s);
		checked++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask

	// compare bits hi..lo of the last read word against the model
	task automatic chk_rd(input string nm, input int hi, input int lo);
		logic [15:0] m;
		m = 16'hffff >> (15 - hi + lo);
		chk(nm, (rd_exp >> lo) & m, (reg_rdata >> lo) & m);
	endtask

	task automatic clr();
		st = cond();
		st[5] = drive_pin;
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end

	initial begin
		repeat (10) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		chk("rdata reset", 16'h0000, reg_rdata);
		repeat (400) begin
			r = xs();
			@(negedge ref_clk);
			// cfg acts at the next edge, the flags two edges later, so the
			// new cfg meets the old flags for two cycles
			cfg = r[21:17];
			st = st | cond();
			drive_pin = r[0] | r[1];
			clk_missing = r[2] & r[3];
			gate_supply_low_flag = r[4] & r[5] & r[6];
			five_volt_low_flag = r[7] & r[8] & r[9];
			boost_low_flag = r[10] & r[11];
			over_temp_flag = r[12] & r[13];
			gnd_loss_flag = r[14] & r[15] & r[16];
			repeat (4) @(negedge ref_clk);
			st = st | cond();
			st[5] = st[5] & drive_pin;
			en = exp_en();
			seen = {4'h0, high_group_enable, low_group_enable};
			chk("enables", {4'h0, en}, seen);
			chk("low en", 16'(en[5:0]), 16'(seen[5:0]));
			chk("low seven", 16'(en[6]), 16'(seen[6]));
			chk("high en", 16'(en[11:7]), 16'(seen[11:7]));
			bad = r[24:22] == 3'h0;
			mcu_u.xfer(1'b1, 1'b0, bad ? 10'h1d1 : deg_pkg::FAULT_LATCH_ADDR);
			if (!bad) begin
				rd_exp = {9'h000, st[6:5], drive_pin, st[3:0]};
			end
			chk("status", rd_exp, reg_rdata);
			chk_rd("clock miss", 6, 6);
			chk_rd("pin history", 5, 5);
			chk_rd("boost", 2, 2);
			chk_rd("supplies", 1, 0);
			chk_rd("over temp", 3, 3);
			if (!bad && cfg.reset_on_read_en) begin
				clr();
			end
			if (r[25]) begin
				mcu_u.xfer(1'b0, 1'b1, deg_pkg::FAULT_LATCH_ADDR);
				clr();
			end
		end
		results();
	end
endmodule
